// ===== hdl/adc_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// Register byte offsets on the bus
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_CTRL2 8'h08
`define OFF_RES_HI 8'h0C
`define OFF_RES_LO 8'h10
`define OFF_IRQ 8'h14

// Control register 0 fields
`define CTRL0_EN_BIT 0
`define CTRL0_GO_BIT 1
`define CTRL0_CHS_LSB 2
`define CTRL0_CHS_MSB 6

// Control register 1 fields
`define CTRL1_PREF_LSB 0
`define CTRL1_PREF_MSB 1
`define CTRL1_ADCS_LSB 4
`define CTRL1_ADCS_MSB 6
`define CTRL1_FMT_BIT 7

// Control register 2 field
`define CTRL2_TRIG_LSB 4
`define CTRL2_TRIG_MSB 7

// Interrupt register fields
`define IRQ_FLAG_BIT 0
`define IRQ_IE_BIT 1

// Reset value of every control register
`define CTRL_RESET 8'h00

// Conversion timing in half periods of the conversion clock (11.5 periods)
`define HALVES_TOTAL 5'd23
`define SAMPLE_HALVES 5'd3
`define FIRST_DECIDE 5'd4
`define LAST_HALF 5'd22

// Clock field code that selects the internal RC clock (low two bits)
`define ADCS_RC_CODE 2'h3

`endif

// ===== hdl/adc_pkg.sv
// Types shared by the converter control modules
package adc_pkg;

	// Sequencer state of the approximation engine
	typedef enum logic [0:0] {
		SAR_IDLE = 1'b0,
		SAR_RUN = 1'b1
	} sar_state_t;

	// Auto-conversion trigger source codes
	typedef enum logic [3:0] {
		TRIG_NONE = 4'h0,
		TRIG_PWM1_INT = 4'h1,
		TRIG_PWM2_INT = 4'h2,
		TRIG_TMR0_OVF = 4'h3,
		TRIG_TMR1_OVF = 4'h4,
		TRIG_TMR2_MATCH = 4'h5,
		TRIG_COMPARATOR = 4'h6,
		TRIG_PWM3_INT = 4'h7,
		TRIG_PWM1_OFS = 4'h8,
		TRIG_PWM2_OFS = 4'h9,
		TRIG_PWM3_OFS = 4'hA
	} trig_sel_t;

	// Four match flags of one PWM channel, three channels
	typedef logic [2:0][3:0] pwm_flag_bank_t;

endpackage : adc_pkg

// ===== hdl/sar_if.sv
// Link between the control registers and the approximation engine
`timescale 1ns/10ps
interface sar_if #(parameter int RES_W = 10);
	logic run; // Conversion requested and converter powered
	logic [2:0] clk_field; // Conversion clock selection
	logic busy; // Engine is converting
	logic done; // One-cycle end pulse, complete or aborted
	logic complete; // Qualifies done: full conversion
	logic [RES_W-1:0] result; // Raw result at done

	// Register side
	modport ctrl (output run, output clk_field, input busy, input done, input complete,
		input result);
	// Engine side
	modport core (input run, input clk_field, output busy, output done, output complete,
		output result);
endinterface : sar_if

// ===== hdl/sar_core.sv
// Successive-approximation sequencer with conversion clock generation
`timescale 1ns/10ps
`include "adc_defs.svh"
module sar_core #(
	parameter int RES_W = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	sar_if.core link,
	input wire logic rc_clk_in,
	input wire logic comp_in,
	output logic [RES_W-1:0] sar_trial
);
	import adc_pkg::*;

	sar_state_t state_q; // Engine state
	logic rc_s1_q, rc_s2_q, rc_s3_q; // RC clock synchroniser and edge stage
	logic rc_edge; // Either edge of the RC clock: one half period
	logic [4:0] div_q; // System clock divider
	logic [4:0] half_len; // Half period in system clocks, minus one
	logic tick; // One half conversion period elapsed
	logic [4:0] hc_q; // Half periods seen
	logic [3:0] nd_q; // Bits decided
	logic [RES_W-1:0] sar_q; // Decided bits
	logic [RES_W-1:0] probe; // Bit under trial
	logic [RES_W-1:0] next_sar; // Decided bits with the present decision
	logic done_q, complete_q; // End pulse and its kind
	logic [RES_W-1:0] result_q; // Result handed back

	// Undecided bits copy the last decided bit
	function automatic logic [RES_W-1:0] fill_bits(input logic [RES_W-1:0] v,
		input logic [3:0] n);
		logic [RES_W-1:0] r;
		r = v;
		if (n != 4'h0) begin
			for (int i = 0; i < RES_W; i++) begin
				if (i < RES_W - int'(n)) begin
					r[i] = v[RES_W-int'(n)];
				end
			end
		end
		return r;
	endfunction : fill_bits

	////////////////////////////////////////////////////////////////////////
	// RC clock crossing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rc_s1_q <= 1'b0;
			rc_s2_q <= 1'b0;
			rc_s3_q <= 1'b0;
		end else begin
			rc_s1_q <= rc_clk_in;
			rc_s2_q <= rc_s1_q;
			rc_s3_q <= rc_s2_q;
		end
	end
	assign rc_edge = rc_s2_q ^ rc_s3_q;

	// Divider half period per clock code
	always_comb begin
		case (link.clk_field)
			3'h0: half_len = 5'h00;
			3'h4: half_len = 5'h01;
			3'h1: half_len = 5'h03;
			3'h5: half_len = 5'h07;
			3'h2: half_len = 5'h0F;
			3'h6: half_len = 5'h1F;
			default: half_len = 5'h00;
		endcase
	end

	// Divider runs only while converting
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 5'h00;
		end else if (state_q == SAR_IDLE || div_q == half_len) begin
			div_q <= 5'h00;
		end else begin
			div_q <= div_q + 5'h01;
		end
	end

	assign tick = (link.clk_field[1:0] == `ADCS_RC_CODE) ? rc_edge : (div_q == half_len);

	// Trial code for the comparator
	always_comb begin
		probe = '0;
		for (int i = 0; i < RES_W; i++) begin
			if (i == RES_W - 1 - int'(nd_q)) begin
				probe[i] = 1'b1;
			end
		end
		next_sar = comp_in ? (sar_q | probe) : sar_q;
		sar_trial = (state_q == SAR_RUN) ? (sar_q | probe) : '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer over 23 half periods
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SAR_IDLE;
			hc_q <= 5'h00;
			nd_q <= 4'h0;
			sar_q <= '0;
			done_q <= 1'b0;
			complete_q <= 1'b0;
			result_q <= '0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				SAR_IDLE: begin
					// Start, but not in the cycle of a previous end
					if (link.run && !done_q) begin
						state_q <= SAR_RUN;
						hc_q <= 5'h00;
						nd_q <= 4'h0;
						sar_q <= '0;
					end
				end
				SAR_RUN: begin
					if (!link.run) begin
						state_q <= SAR_IDLE;
						done_q <= 1'b1;
						complete_q <= 1'b0;
						result_q <= fill_bits(sar_q, nd_q);
					end else if (tick) begin
						hc_q <= hc_q + 5'h01;
						if (hc_q >= `FIRST_DECIDE && !hc_q[0]) begin
							sar_q <= next_sar;
							nd_q <= nd_q + 4'h1;
						end
						if (hc_q == `LAST_HALF) begin
							// Full conversion ends
							state_q <= SAR_IDLE;
							done_q <= 1'b1;
							complete_q <= 1'b1;
							result_q <= next_sar;
						end
					end
				end
				default: state_q <= SAR_IDLE;
			endcase
		end
	end

	assign link.busy = (state_q == SAR_RUN);
	assign link.done = done_q;
	assign link.complete = complete_q;
	assign link.result = result_q;

	// Half periods counted since start, for checking
	logic [4:0] ticks_seen_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ticks_seen_q <= 5'h00;
		end else if (state_q == SAR_IDLE) begin
			ticks_seen_q <= 5'h00;
		end else if (tick) begin
			ticks_seen_q <= ticks_seen_q + 5'h01;
		end
	end

	a_conv_length: assert property (@(posedge hclk) disable iff (!hresetn)
		(done_q && complete_q) |-> (ticks_seen_q == `HALVES_TOTAL))
		else $error("conversion did not last 23 half periods");

endmodule : sar_core

// ===== hdl/adc_sequencing_control.sv
// Converter control: registers, start and abort, sleep handling, auto trigger
//
// Function
// - Result format bit selects right/left justification
// - Enable bit powers the converter
// - Writing busy bit starts; hardware clears
// - Busy bit reads one while converting
// - Completion clears busy, sets flag, loads
// - Abort loads partial, undecided bits copy
// - Reset restores registers and stops conversion
// - Sleep conversion only with RC clock
// - Sleep completion with interrupt enabled wakes
// - Sleep completion without interrupt powers down
// - Sleep with other clock aborts, powers down
// - Trigger rising edge sets busy bit
// - Four-bit field selects trigger source
// - Enabled PWM match interrupts trigger conversion
// - Channel field routes inputs or none
// - Clock field picks divider or RC
// - Reference field picks supply, pin, fixed
// - Trigger codes decode, reserved means none
// - Conversion lasts eleven and half periods
// - Flag set every completion, software clears
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "adc_defs.svh"
module adc_sequencing_control #(
	parameter int RES_W = 10
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic sleep_mode,
	input wire logic timer0_overflow_event,
	input wire logic timer1_overflow_event,
	input wire logic timer2_match_event,
	input wire logic comparator_sync_output,
	input wire logic [2:0] pwm_offset_match,
	input wire adc_pkg::pwm_flag_bank_t pwm_match_flags,
	input wire adc_pkg::pwm_flag_bank_t pwm_interrupt_enable_reg,
	input wire logic rc_clk_in,
	input wire logic comp_in,
	output logic [RES_W-1:0] sar_trial,
	output logic sample_hold,
	output logic converter_power,
	output logic [6:0] channel_route,
	output logic [2:0] reference_route,
	output logic wake_request,
	output logic converter_interrupt_flag
);
	import adc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	sar_if #(.RES_W(RES_W)) link (); // Engine link

	// Bus data phase
	logic dph_q; // Data phase pending
	logic wr_q; // Pending transfer is a write
	logic [7:0] addr_q; // Pending byte offset
	logic acc; // Address phase accepted
	logic wr_en; // Write data valid this cycle

	// Control fields
	logic en_q; // Converter enable bit
	logic go_q; // Conversion busy bit
	logic [4:0] chs_q; // Channel select field
	logic fmt_q; // Result format bit
	logic [2:0] adcs_q; // Conversion clock field
	logic [1:0] pref_q; // Positive reference field
	trig_sel_t trig_q; // Trigger select field
	logic ie_q; // Converter interrupt enable
	logic flag_q; // Converter interrupt flag
	logic [7:0] res_hi_q; // Result high byte
	logic [7:0] res_lo_q; // Result low byte
	logic pdown_q; // Converter powered down in sleep
	logic wake_q; // Wake pulse
	logic trig_prev_q; // Trigger level one cycle ago

	// Decoded events
	logic wr_ctrl0, wr_ctrl1, wr_ctrl2, wr_irq; // Register write strobes
	logic rc_sel; // RC conversion clock selected
	logic en_next; // Enable after this cycle
	logic kill; // Conversion must stop now
	logic sw_set, sw_clr; // Software start and abort
	logic trig_lvl; // Selected trigger source level
	logic trig_edge; // Rising edge of it
	logic hw_set; // Hardware start
	logic [2:0] pwm_int; // Enabled PWM match interrupts
	logic finish; // Full conversion ended
	logic [7:0] rd_byte; // Selected read register

	////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY

	assign acc = hsel && hready && htrans[1];

	// Capture the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			dph_q <= acc;
			if (acc) begin
				wr_q <= hwrite;
				addr_q <= haddr[7:0];
			end
		end
	end

	assign wr_en = dph_q && wr_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Write strobes by offset
	always_comb begin
		wr_ctrl0 = 1'b0;
		wr_ctrl1 = 1'b0;
		wr_ctrl2 = 1'b0;
		wr_irq = 1'b0;
		if (wr_en && addr_q == `OFF_CTRL0) begin
			wr_ctrl0 = 1'b1;
		end else if (wr_en && addr_q == `OFF_CTRL1) begin
			wr_ctrl1 = 1'b1;
		end else if (wr_en && addr_q == `OFF_CTRL2) begin
			wr_ctrl2 = 1'b1;
		end else if (wr_en && addr_q == `OFF_IRQ) begin
			wr_irq = 1'b1;
		end
	end

	// Read mux; unused and unmapped bits read zero
	always_comb begin
		rd_byte = 8'h00;
		if (addr_q == `OFF_CTRL0) begin
			rd_byte = {1'b0, chs_q, go_q, en_q};
		end else if (addr_q == `OFF_CTRL1) begin
			rd_byte = {fmt_q, adcs_q, 2'h0, pref_q};
		end else if (addr_q == `OFF_CTRL2) begin
			rd_byte = {trig_q, 4'h0};
		end else if (addr_q == `OFF_RES_HI) begin
			rd_byte = res_hi_q;
		end else if (addr_q == `OFF_RES_LO) begin
			rd_byte = res_lo_q;
		end else if (addr_q == `OFF_IRQ) begin
			rd_byte = {6'h00, ie_q, flag_q};
		end
		hrdata = (dph_q && !wr_q) ? {24'h000000, rd_byte} : 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= 1'b0;
			chs_q <= 5'h00;
		end else if (wr_ctrl0) begin
			en_q <= hwdata[`CTRL0_EN_BIT];
			chs_q <= hwdata[`CTRL0_CHS_MSB:`CTRL0_CHS_LSB];
		end
	end

	// Format, clock and reference fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fmt_q <= 1'b0;
			adcs_q <= 3'h0;
			pref_q <= 2'h0;
		end else if (wr_ctrl1) begin
			fmt_q <= hwdata[`CTRL1_FMT_BIT];
			adcs_q <= hwdata[`CTRL1_ADCS_MSB:`CTRL1_ADCS_LSB];
			pref_q <= hwdata[`CTRL1_PREF_MSB:`CTRL1_PREF_LSB];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_q <= TRIG_NONE;
		end else if (wr_ctrl2) begin
			trig_q <= trig_sel_t'(hwdata[`CTRL2_TRIG_MSB:`CTRL2_TRIG_LSB]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger selection

	// PWM interrupt is any enabled match flag
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pwm_int[i] = |(pwm_match_flags[i] & pwm_interrupt_enable_reg[i]);
		end
	end

	// Source decode, reserved codes select nothing
	always_comb begin
		case (trig_q)
			TRIG_PWM1_INT: trig_lvl = pwm_int[0];
			TRIG_PWM2_INT: trig_lvl = pwm_int[1];
			TRIG_PWM3_INT: trig_lvl = pwm_int[2];
			TRIG_TMR0_OVF: trig_lvl = timer0_overflow_event;
			TRIG_TMR1_OVF: trig_lvl = timer1_overflow_event;
			TRIG_TMR2_MATCH: trig_lvl = timer2_match_event;
			TRIG_COMPARATOR: trig_lvl = comparator_sync_output;
			TRIG_PWM1_OFS: trig_lvl = pwm_offset_match[0];
			TRIG_PWM2_OFS: trig_lvl = pwm_offset_match[1];
			TRIG_PWM3_OFS: trig_lvl = pwm_offset_match[2];
			default: trig_lvl = 1'b0;
		endcase
	end

	// Previous trigger level for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_lvl;
		end
	end

	assign trig_edge = trig_lvl && !trig_prev_q;
	assign hw_set = trig_edge && en_q;

	////////////////////////////////////////////////////////////////////////
	// Start, abort and completion

	assign rc_sel = (adcs_q[1:0] == `ADCS_RC_CODE);
	assign en_next = wr_ctrl0 ? hwdata[`CTRL0_EN_BIT] : en_q;
	// Sleep with a divided clock stops the conversion
	assign kill = !en_next || (sleep_mode && !rc_sel) || pdown_q;
	// Start needs the converter already enabled
	assign sw_set = wr_ctrl0 && hwdata[`CTRL0_GO_BIT] && en_q;
	assign sw_clr = wr_ctrl0 && !hwdata[`CTRL0_GO_BIT];
	assign finish = link.done && link.complete;

	// Busy bit: kill clears it first, then starts set it, then ends clear it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_q <= 1'b0;
		end else if (kill) begin
			go_q <= 1'b0;
		end else if (sw_set || hw_set) begin
			go_q <= 1'b1;
		end else if (finish || sw_clr) begin
			go_q <= 1'b0;
		end
	end

	// Sleep power-down: at once with a divided clock, on RC after completion without interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pdown_q <= 1'b0;
		end else if (!sleep_mode) begin
			pdown_q <= 1'b0;
		end else if (!rc_sel) begin
			pdown_q <= 1'b1;
		end else if (finish && !ie_q) begin
			pdown_q <= 1'b1;
		end
	end

	// Wake pulse on sleep completion with interrupt enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= finish && sleep_mode && ie_q;
		end
	end

	// Flag sticky; write one clears, completion wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= 1'b0;
			ie_q <= 1'b0;
		end else begin
			if (finish) begin
				flag_q <= 1'b1;
			end else if (wr_irq && hwdata[`IRQ_FLAG_BIT]) begin
				flag_q <= 1'b0;
			end
			if (wr_irq) begin
				ie_q <= hwdata[`IRQ_IE_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_hi_q <= 8'h00;
			res_lo_q <= 8'h00;
		end else if (link.done) begin
			if (fmt_q) begin
				res_hi_q <= {6'h00, link.result[9:8]};
				res_lo_q <= link.result[7:0];
			end else begin
				res_hi_q <= link.result[9:2];
				res_lo_q <= {link.result[1:0], 6'h00};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Engine and analog outputs

	// Engine runs while busy bit set and powered
	assign link.run = go_q && converter_power;
	assign link.clk_field = adcs_q;

	sar_core #(.RES_W(RES_W)) u_core (
		.hclk(hclk),
		.hresetn(hresetn),
		.link(link),
		.rc_clk_in(rc_clk_in),
		.comp_in(comp_in),
		.sar_trial(sar_trial)
	);

	// Power only while enabled and not sleeping it off
	assign converter_power = en_q && !pdown_q;
	// Track input until the engine holds it
	assign sample_hold = link.busy;
	assign wake_request = wake_q;
	assign converter_interrupt_flag = flag_q;

	// Channel routing, unused codes connect nothing
	always_comb begin
		channel_route = 7'h00;
		if (chs_q <= 5'h03) begin
			channel_route[chs_q[1:0]] = 1'b1;
		end else if (chs_q == 5'h1D) begin
			channel_route[4] = 1'b1;
		end else if (chs_q == 5'h1E) begin
			channel_route[5] = 1'b1;
		end else if (chs_q == 5'h1F) begin
			channel_route[6] = 1'b1;
		end
	end

	// Reference routing, reserved code connects nothing
	always_comb begin
		case (pref_q)
			2'h0: reference_route = 3'h1;
			2'h2: reference_route = 3'h2;
			2'h3: reference_route = 3'h4;
			default: reference_route = 3'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_right_just: assert property (@(posedge hclk) disable iff (!hresetn)
		(link.done && fmt_q) |=> (res_hi_q[7:2] == 6'h00 && res_lo_q == $past(link.result[7:0])))
		else $error("right justified result wrong");

	a_left_just: assert property (@(posedge hclk) disable iff (!hresetn)
		(link.done && !fmt_q) |=> (res_lo_q[5:0] == 6'h00 && res_hi_q == $past(link.result[9:2])))
		else $error("left justified result wrong");

	a_end_clears_go: assert property (@(posedge hclk) disable iff (!hresetn)
		(finish && !sw_set && !hw_set) |=> (!go_q && flag_q))
		else $error("completion did not clear busy and set flag");

	a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
		(flag_q && !(wr_irq && hwdata[`IRQ_FLAG_BIT])) |=> flag_q)
		else $error("flag lost without software clear");

	a_start_enabled: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(go_q) |-> $past(en_q))
		else $error("conversion started while disabled");

	a_sleep_abort: assert property (@(posedge hclk) disable iff (!hresetn)
		(sleep_mode && !rc_sel && en_q && !wr_ctrl0) |=> (!go_q && !converter_power && en_q))
		else $error("sleep with divided clock did not abort");

	a_trig_start: assert property (@(posedge hclk) disable iff (!hresetn)
		(trig_edge && en_q && !kill) |=> go_q ##[1:2] link.busy)
		else $error("trigger edge did not start conversion");

	a_wake_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		(finish && sleep_mode && ie_q) |=> (wake_request ##1 !wake_request))
		else $error("no single wake pulse on sleep completion");

	c_complete: cover property (@(posedge hclk) disable iff (!hresetn) finish);
	c_abort: cover property (@(posedge hclk) disable iff (!hresetn)
		link.done && !link.complete);
	c_trigger: cover property (@(posedge hclk) disable iff (!hresetn) hw_set && !go_q);
	c_wake: cover property (@(posedge hclk) disable iff (!hresetn) wake_request);

endmodule : adc_sequencing_control

// ===== dv/analog_model.sv
// Behavioural comparator facing the converter
`timescale 1ns/10ps
module analog_model (
	input wire logic [9:0] sar_trial,
	input wire logic [9:0] level,
	output logic comp_in
);
	// Ideal comparator: high while the held input reaches the trial code
	assign comp_in = (level >= sar_trial);
endmodule : analog_model

// ===== dv/adc_sequencing_control_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module adc_sequencing_control_test;
	import adc_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_mode = 0;
	logic hready, hreadyout, hresp, comp_in, converter_power, converter_interrupt_flag;
	logic sample_hold, wake_request; // Hold and wake outputs
	logic rc_clk = 0, rc_on = 0; // RC conversion clock and its gate
	logic [1:0] rc_div = 0; // RC clock divider
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, reference_route;
	logic [10:1] tg = '0; // Trigger sources indexed by select code
	logic [9:0] level = '0, sar_trial;
	logic [6:0] channel_route;
	pwm_flag_bank_t pmf;
	pwm_flag_bank_t pie = 12'h888; // PWM match interrupt enables
	int fails = 0, n_checks = 0;
	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	assign pmf = {tg[7], 3'h0, tg[2], 3'h0, tg[1], 3'h0};
	// RC conversion clock: one edge every four cycles while enabled
	always @(posedge hclk) if (rc_on) {rc_clk, rc_div} <= {rc_clk, rc_div} + 3'h1;
	adc_sequencing_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_mode(sleep_mode),
		.timer0_overflow_event(tg[3]), .timer1_overflow_event(tg[4]),
		.timer2_match_event(tg[5]), .comparator_sync_output(tg[6]),
		.pwm_offset_match(tg[10:8]), .pwm_match_flags(pmf), .pwm_interrupt_enable_reg(pie),
		.rc_clk_in(rc_clk), .comp_in(comp_in), .sar_trial(sar_trial),
		.sample_hold(sample_hold),
		.converter_power(converter_power), .channel_route(channel_route),
		.reference_route(reference_route), .wake_request(wake_request),
		.converter_interrupt_flag(converter_interrupt_flag));
	analog_model ana (.sar_trial(sar_trial), .level(level), .comp_in(comp_in));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	// Single transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	// Poll the busy bit, bounded
	task automatic wait_idle();
		for (int k = 0; k < 60 && rd[1] !== 1'b0; k++) bus(1'b0, 8'h00, 32'h0);
	endtask : wait_idle
	task automatic t_reset();
		for (int a = 0; a < 36; a += 4) begin
			bus(1'b0, a[7:0], 32'h0);
			chk("reg", rd, 32'h0);
		end
		chk("chan", channel_route, 7'h01);
		chk("ref", reference_route, 3'h1);
		chk("resp", hresp, 1'b0);
		chk("trial", sar_trial, 10'h000);
		bus(1'b1, 8'h00, 32'h2);
		bus(1'b1, 8'h00, 32'h3);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctl0", rd, 32'h1);
		chk("pwr", converter_power, 1'b1);
		bus(1'b1, 8'h00, 32'h0);
		@(negedge hclk);
		chk("pwr", converter_power, 1'b0);
	endtask : t_reset
	task automatic t_route();
		for (int c = 0; c < 32; c++) begin
			bus(1'b1, 8'h00, c << 2);
			@(negedge hclk);
			chk("chan", channel_route, c < 4 ? 1 << c : c > 28 ? 1 << (c - 25) : 0);
		end
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, 8'h04, r);
			@(negedge hclk);
			chk("ref", reference_route, r == 0 ? 1 : r == 2 ? 2 : r == 3 ? 4 : 0);
		end
	endtask : t_route
	task automatic t_conv(input logic fmt, input logic [9:0] v);
		level <= v;
		bus(1'b1, 8'h04, {24'h0, fmt, 7'h0});
		// configure, enable, start, poll, read, clear
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b1, 8'h00, 32'h3);
		bus(1'b0, 8'h00, 32'h0);
		chk("busy", rd[1], 1'b1);
		wait_idle();
		chk("busy", rd[1], 1'b0);
		bus(1'b0, 8'h0C, 32'h0);
		chk("hi", rd, fmt ? v[9:8] : v[9:2]);
		bus(1'b0, 8'h10, 32'h0);
		chk("lo", rd, fmt ? v[7:0] : {v[1:0], 6'h0});
		chk("flag", converter_interrupt_flag, 1'b1);
		bus(1'b1, 8'h14, 32'h1);
		bus(1'b0, 8'h14, 32'h0);
		chk("flag", rd[0], 1'b0);
	endtask : t_conv
	task automatic t_abort();
		level <= 10'h3FF;
		bus(1'b1, 8'h00, 32'h3);
		repeat (8) @(posedge hclk);
		bus(1'b1, 8'h00, 32'h1);
		bus(1'b0, 8'h0C, 32'h0);
		chk("hi", rd, 32'h3);
		bus(1'b0, 8'h10, 32'h0);
		chk("lo", rd, 32'hFF);
		bus(1'b0, 8'h14, 32'h0);
		chk("flag", rd[0], 1'b0);
	endtask : t_abort
	task automatic t_sleep();
		bus(1'b1, 8'h00, 32'h3);
		sleep_mode <= 1'b1;
		repeat (3) @(posedge hclk);
		chk("pwr", converter_power, 1'b0);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctl0", rd[1:0], 2'h1);
		sleep_mode <= 1'b0;
	endtask : t_sleep
	task automatic t_trig();
		for (int c = 0; c < 12; c++) begin
			bus(1'b1, 8'h08, c << 4);
			// source chosen a cycle before its edge
			@(posedge hclk);
			// Reserved and none codes see every source rise
			if (c inside {[1:10]}) tg[c] <= 1'b1;
			else tg <= '1;
			@(posedge hclk);
			tg <= '0;
			bus(1'b0, 8'h00, 32'h0);
			chk("trig", rd[1], c inside {[1:10]});
			wait_idle();
		end
		// a flag whose enable is off starts nothing
		pie <= 12'h777;
		bus(1'b1, 8'h08, 32'h10);
		@(posedge hclk);
		tg[1] <= 1'b1;
		@(posedge hclk);
		tg[1] <= 1'b0;
		pie <= 12'h888;
		bus(1'b0, 8'h00, 32'h0);
		chk("pwmie", rd[1], 1'b0);
	endtask : t_trig
	// Conversion in sleep on the RC clock, with and without interrupt
	task automatic t_rcsleep(input logic ie);
		bus(1'b1, 8'h14, {30'h0, ie, 1'b1});
		bus(1'b1, 8'h04, 32'h30);
		level <= 10'h155;
		rc_on <= 1'b1;
		bus(1'b1, 8'h00, 32'h3);
		sleep_mode <= 1'b1;
		for (int k = 0; k < 300 && converter_interrupt_flag !== 1'b1; k++) begin
			@(negedge hclk);
			if (k == 20) chk("hold", sample_hold, 1'b1);
		end
		chk("wake", wake_request, ie);
		@(negedge hclk);
		chk("wake", wake_request, 1'b0);
		chk("pwr", converter_power, ie);
		chk("hold", sample_hold, 1'b0);
		bus(1'b0, 8'h00, 32'h0);
		chk("ctl0", rd[1:0], 2'h1);
		bus(1'b0, 8'h0C, 32'h0);
		chk("hi", rd, 32'h55);
		sleep_mode <= 1'b0;
		rc_on <= 1'b0;
	endtask : t_rcsleep
	task automatic t_rerun();
		bus(1'b1, 8'h00, 32'h3);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 8'h00, 32'h0);
		chk("ctl0", rd, 32'h0);
	endtask : t_rerun
	task automatic end_of_test();
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_route();
		t_conv(1'b0, 10'h3C6);
		t_conv(1'b1, 10'h2A5);
		t_abort();
		t_sleep();
		t_trig();
		t_rcsleep(1'b1);
		t_rcsleep(1'b0);
		t_rerun();
		end_of_test();
	end
	// Watchdog against a hung handshake
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
endmodule : adc_sequencing_control_test
